// ---- hw/dfrs_persist.sv ----
// Persistence timer: hit once cond has held for limit ticks
`timescale 1ns/1ps
module dfrs_persist (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        tick,
	input  wire logic        cond,
	input  wire logic [15:0] limit,
	output logic             hit
);
	logic [15:0] cnt_reg;

	// Any drop of cond restarts the count; the count saturates
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_reg <= 16'h0000;
		else if (!cond)
			cnt_reg <= 16'h0000;
		else if (tick && cnt_reg != 16'hffff)
			cnt_reg <= cnt_reg + 16'h0001;
	end

	assign hit = cond && (cnt_reg >= limit);
endmodule

// ---- hw/dfrs_tick.sv ----
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
module dfrs_tick #(
	parameter int DIV = 4
) (
	input  wire logic clk,
	input  wire logic rst_n,
	output logic      tick
);
	logic [31:0] cnt_reg;

	if (DIV < 2)
	begin : g_bad_div
		$error("dfrs_tick: DIV must be at least 2");
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b0;
		end
		else if (cnt_reg == 32'(DIV - 1))
		begin
			cnt_reg <= 32'h0000_0000;
			tick <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
			tick <= 1'b0;
		end
	end
endmodule

// ---- hw/dfrs_top.sv ----
// Drive fault detection, restart supervisor and relay selector
// Behaviour
// [RULE1] Lost follower uses programmed lost setpoint or holds last setpoint
// [RULE2] Follower is lost once it falls to the programmed lost level
// [RULE3] Relay polarity: idle de-energised or idle energised, same choices
// [RULE4] Relay follows one selectable status, fault by default
// [RULE5] Relay may instead trip on comparison of one selected quantity
// [RULE6] Terminal sources act only in remote; keypad only in local
// [RULE7] Autostart at power-up with autostart, PLC run and PLC inputs closed
// [RULE8] With PLC run enabled, PLC inputs start and stop the drive
// [RULE9] Stop from terminal only, or from terminal or keypad
// [RULE10] Fault history keeps current and four prior faults, shifting
// [RULE11] Clear-history setting erases all history entries
// [RULE12] Open-coil check faults on no clutch current while output applied
// [RULE13] Feedback check faults on no speed feedback while running
// [RULE14] Fault indicated only after persisting for the programmed delay
// [RULE15] Keypad check faults when the keypad is disconnected
// [RULE16] Overspeed check faults; action setting chooses run or stop
// [RULE17] Underspeed check faults; own action setting chooses run or stop
// [RULE18] Speed trips need the speed beyond limit longer than allowed time
// [RULE19] Power-up restart enters run after the power-up delay
// [RULE20] Fault restart re-enters run after the post-fault delay
// [RULE21] Automatic restart attempts are counted and limited
// [RULE22] Attempt counter clears after continuous run for clear time
// [RULE23] At the retry limit restarts stop; fault held until operator reset
`timescale 1ns/1ps
module dfrs_top
	import dfrs_pkg::*;
#(
	parameter int TICK_CYCLES_P = dfrs_pkg::TICK_CYCLES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        REMOTE_MODE,
	input  wire logic        AUTO_MODE,
	input  wire logic        TERM_START,
	input  wire logic        TERM_STOP,
	input  wire logic        KEY_START,
	input  wire logic        KEY_STOP,
	input  wire logic        PLC_START,
	input  wire logic        KEYPAD_PRESENT,
	input  wire logic        SPEED_FB_OK,
	input  wire logic [15:0] SPEED,
	input  wire logic [15:0] SETPOINT_IN,
	input  wire logic [15:0] FOLLOWER,
	input  wire logic [15:0] MOTOR_AMPS,
	input  wire logic [15:0] CLUTCH_AMPS,
	input  wire logic [15:0] BRAKE_AMPS,
	input  wire logic        TORQUE_LIMIT,
	input  wire logic        AT_SETPOINT,
	input  wire logic        TORQUE_MODE,
	input  wire logic        ESTOP_OPEN,
	input  wire logic        STOPPING,
	input  wire logic        COASTING,
	input  wire logic        JOGGING,
	output logic             RUN_CMD,
	output logic             RELAY_OUT,
	output logic             FAULT_IND,
	output logic      [15:0] ACTIVE_SETPOINT
);
	import dfrs_pkg::*;

	function automatic logic [15:0] sat_inc(input logic [15:0] v);
		return (v == 16'hffff) ? v : v + 16'h0001;
	endfunction

	logic [31:0]        ctrl_reg, relay_reg, flost_reg, speed_reg;
	logic [31:0]        time1_reg, time2_reg, retry_reg, rd_data;
	dfrs_state_t        state_reg, state_q_reg;
	dfrs_fault_t        fault_code_reg, fault_now;
	dfrs_fault_t        hist_reg [HIST_N];
	logic [15:0]        wait_cnt_reg, run_time_reg, hold_sp_reg;
	logic [RETRY_W-1:0] retry_cnt_reg;
	logic               fault_latched_reg, op_reset_reg, tick;
	logic               setup, access, running, follower_lost;
	logic               follower_loss_choice, terminal_or_panel_stop;
	logic               open_winding_check_on, feedback_loss_check_on;
	logic               panel_disconnect_check_on, high_speed_check_on;
	logic               high_speed_response, low_speed_check_on;
	logic               low_speed_response, controller_powerup_start;
	logic               controller_run_follow, clear_history;
	logic               open_raw, fb_raw, panel_raw, hi_raw, lo_raw;
	logic               hi_trip, lo_trip, fault_sensed, ind_hit, ind_rise;
	logic               start_req, stop_req, autostart, stop_kind;
	logic               pwr_done, restart_go, relay_cond, cmp_hit;
	logic [18:0]        rs;
	logic [15:0]        qty, dev_up, dev_dn;
	logic [RETRY_W-1:0] retry_limit;

	assign follower_loss_choice = ctrl_reg[C_LOSS_CHOICE];
	assign terminal_or_panel_stop = ctrl_reg[C_STOP_PANEL];
	assign open_winding_check_on = ctrl_reg[C_OPEN_CHK];
	assign feedback_loss_check_on = ctrl_reg[C_FB_CHK];
	assign panel_disconnect_check_on = ctrl_reg[C_PANEL_CHK];
	assign high_speed_check_on = ctrl_reg[C_HI_CHK];
	assign high_speed_response = ctrl_reg[C_HI_STOP];
	assign low_speed_check_on = ctrl_reg[C_LO_CHK];
	assign low_speed_response = ctrl_reg[C_LO_STOP];
	assign controller_powerup_start = ctrl_reg[C_PLC_AUTO];
	assign controller_run_follow = ctrl_reg[C_PLC_RUN];
	assign clear_history = ctrl_reg[C_CLR_HIST];
	assign retry_limit = retry_reg[RETRY_W-1:0];

	dfrs_tick #(.DIV(TICK_CYCLES_P)) u_tick (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.tick  (tick)
	);

	// APB slave: no wait states, read data captured in the setup cycle
	assign setup = PSEL && !PENABLE;
	assign access = PSEL && PENABLE && PREADY;

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end
		else
		begin
			PREADY <= setup;
			PSLVERR <= setup && (PADDR > A_HIST || PADDR[1:0] != 2'b00);
			PRDATA <= (setup && !PWRITE) ? rd_data : 32'h0000_0000;
		end
	end

	always_comb
	begin
		case (PADDR)
			A_CTRL: rd_data = ctrl_reg;
			A_RELAY: rd_data = relay_reg;
			A_FLOST: rd_data = flost_reg;
			A_SPEED: rd_data = speed_reg;
			A_TIME1: rd_data = time1_reg;
			A_TIME2: rd_data = time2_reg;
			A_RETRY: rd_data = retry_reg;
			A_STATUS: rd_data = {ACTIVE_SETPOINT, 4'h0, retry_cnt_reg,
				2'b00, RUN_CMD, follower_lost, fault_latched_reg, state_reg};
			A_HIST: rd_data = {12'h000, hist_reg[4], hist_reg[3],
				hist_reg[2], hist_reg[1], hist_reg[0]};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			ctrl_reg <= CTRL_RST;
			relay_reg <= RELAY_RST;
			flost_reg <= FLOST_RST;
			speed_reg <= SPEED_RST;
			time1_reg <= TIME1_RST;
			time2_reg <= TIME2_RST;
			retry_reg <= RETRY_RST;
		end
		else if (access && PWRITE)
		begin
			case (PADDR)
				A_CTRL: ctrl_reg <= PWDATA;
				A_RELAY: relay_reg <= PWDATA;
				A_FLOST: flost_reg <= PWDATA;
				A_SPEED: speed_reg <= PWDATA;
				A_TIME1: time1_reg <= PWDATA;
				A_TIME2: time2_reg <= PWDATA;
				A_RETRY: retry_reg <= PWDATA;
				default: ;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			op_reset_reg <= 1'b0;
		else
			op_reset_reg <= access && PWRITE && PADDR == A_CMD
				&& PWDATA[CMD_RESET];
	end

	// Follower loss and setpoint selection
	assign follower_lost = AUTO_MODE && FOLLOWER <= flost_reg[15:0]; // RULE2

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			hold_sp_reg <= 16'h0000;
			ACTIVE_SETPOINT <= 16'h0000;
		end
		else
		begin
			if (!follower_lost)
				hold_sp_reg <= SETPOINT_IN;
			if (!follower_lost)
				ACTIVE_SETPOINT <= SETPOINT_IN;
			else if (follower_loss_choice) // RULE1
				ACTIVE_SETPOINT <= flost_reg[31:16];
			else
				ACTIVE_SETPOINT <= hold_sp_reg;
		end
	end

	// Fault sensing; checks that need output only look while running
	assign running = state_reg == ST_RUN;
	assign open_raw = open_winding_check_on && running
		&& CLUTCH_AMPS == 16'h0000; // RULE12
	assign fb_raw = feedback_loss_check_on && running && !SPEED_FB_OK; // RULE13
	assign panel_raw = panel_disconnect_check_on && !KEYPAD_PRESENT; // RULE15
	assign hi_raw = high_speed_check_on && SPEED >= speed_reg[15:0]; // RULE16
	assign lo_raw = low_speed_check_on && running
		&& SPEED <= speed_reg[31:16]; // RULE17

	// Speed trips need strictly more than the allowed time
	dfrs_persist u_hi (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.cond  (hi_raw),
		.limit (sat_inc(time1_reg[31:16])),
		.hit   (hi_trip)
	); // RULE18
	dfrs_persist u_lo (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.cond  (lo_raw),
		.limit (sat_inc(time1_reg[31:16])),
		.hit   (lo_trip)
	); // RULE18

	assign fault_sensed = open_raw || fb_raw || panel_raw || hi_trip
		|| lo_trip;
	dfrs_persist u_ind (
		.clk   (CORE_CLK),
		.rst_n (RST_N),
		.tick  (tick),
		.cond  (fault_sensed),
		.limit (sat_inc(time1_reg[15:0])),
		.hit   (ind_hit)
	); // RULE14
	assign ind_rise = ind_hit && !FAULT_IND;

	always_comb
	begin
		if (open_raw)
			fault_now = FC_OPEN_COIL;
		else if (fb_raw)
			fault_now = FC_FB_LOSS;
		else if (panel_raw)
			fault_now = FC_PANEL;
		else if (hi_trip)
			fault_now = FC_OVERSPEED;
		else if (lo_trip)
			fault_now = FC_UNDERSPEED;
		else
			fault_now = FC_NONE;
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			FAULT_IND <= 1'b0;
			fault_code_reg <= FC_NONE;
		end
		else
		begin
			FAULT_IND <= ind_hit;
			if (ind_rise)
				fault_code_reg <= fault_now;
		end
	end

	// A new fault wins over a clear in the same cycle
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			fault_latched_reg <= 1'b0;
		else if (ind_rise)
			fault_latched_reg <= 1'b1;
		else if (op_reset_reg || restart_go)
			fault_latched_reg <= 1'b0;
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			for (int i = 0; i < HIST_N; i++)
				hist_reg[i] <= FC_NONE;
		end
		else if (ind_rise)
		begin
			hist_reg[0] <= fault_now; // RULE10
			for (int i = 1; i < HIST_N; i++)
				hist_reg[i] <= hist_reg[i-1];
		end
		else if (clear_history)
		begin
			for (int i = 0; i < HIST_N; i++)
				hist_reg[i] <= FC_NONE; // RULE11
		end
	end

	// Speed faults may be set to keep running
	always_comb
	begin
		case (fault_code_reg)
			FC_OVERSPEED: stop_kind = high_speed_response; // RULE16
			FC_UNDERSPEED: stop_kind = low_speed_response; // RULE17
			default: stop_kind = 1'b1;
		endcase
	end

	// Start and stop sources
	assign start_req = REMOTE_MODE
		? (controller_run_follow ? PLC_START : TERM_START) // RULE8
		: KEY_START; // RULE6
	assign stop_req = ESTOP_OPEN || (REMOTE_MODE && TERM_STOP)
		|| (!REMOTE_MODE && terminal_or_panel_stop && KEY_STOP) // RULE9
		|| (REMOTE_MODE && controller_run_follow && !PLC_START); // RULE8
	assign autostart = controller_powerup_start && controller_run_follow
		&& REMOTE_MODE && PLC_START; // RULE7
	assign pwr_done = wait_cnt_reg >= time2_reg[15:0];
	assign restart_go = state_reg == ST_FLT_WAIT && !op_reset_reg
		&& state_q_reg == ST_FLT_WAIT
		&& wait_cnt_reg >= time2_reg[31:16]; // RULE20

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			state_reg <= ST_PWR_WAIT;
		else
		begin
			case (state_reg)
				ST_PWR_WAIT:
					if (autostart) // RULE7
						state_reg <= ST_RUN;
					else if (pwr_done && state_q_reg == ST_PWR_WAIT)
						state_reg <= (ctrl_reg[C_PWR_RST] && !stop_req)
							? ST_RUN : ST_IDLE; // RULE19
				ST_IDLE:
					if (start_req && !stop_req && !fault_latched_reg)
						state_reg <= ST_RUN;
				ST_RUN:
					if (FAULT_IND && stop_kind)
						state_reg <= (ctrl_reg[C_FLT_RST]
							&& retry_cnt_reg < retry_limit) // RULE21
							? ST_FLT_WAIT : ST_LOCKED; // RULE23
					else if (stop_req)
						state_reg <= ST_IDLE;
				ST_FLT_WAIT:
					if (op_reset_reg)
						state_reg <= ST_IDLE;
					else if (restart_go)
						state_reg <= ST_RUN; // RULE20
				ST_LOCKED:
					if (op_reset_reg)
						state_reg <= ST_IDLE; // RULE23
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Timers restart on every state change
	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_q_reg <= ST_PWR_WAIT;
			wait_cnt_reg <= 16'h0000;
			run_time_reg <= 16'h0000;
			RUN_CMD <= 1'b0;
		end
		else
		begin
			state_q_reg <= state_reg;
			RUN_CMD <= running;
			if (state_reg != state_q_reg)
				wait_cnt_reg <= 16'h0000;
			else if (tick)
				wait_cnt_reg <= sat_inc(wait_cnt_reg);
			if (!running)
				run_time_reg <= 16'h0000;
			else if (tick)
				run_time_reg <= sat_inc(run_time_reg);
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			retry_cnt_reg <= '0;
		else if (op_reset_reg)
			retry_cnt_reg <= '0;
		else if (restart_go)
			retry_cnt_reg <= retry_cnt_reg + 1'b1; // RULE21
		else if (running && run_time_reg >= retry_reg[31:16])
			retry_cnt_reg <= '0; // RULE22
	end

	// Relay selection
	always_comb
	begin
		rs = '0;
		rs[RS_RESTART] = state_reg == ST_FLT_WAIT
			|| state_reg == ST_PWR_WAIT;
		rs[RS_TRQ_LIM] = TORQUE_LIMIT;
		rs[RS_AT_SP] = AT_SETPOINT;
		rs[RS_FOL_LOST] = follower_lost;
		rs[RS_FB_LOST] = !SPEED_FB_OK;
		rs[RS_SPD_MODE] = !TORQUE_MODE;
		rs[RS_TRQ_MODE] = TORQUE_MODE;
		rs[RS_LOCAL] = !REMOTE_MODE;
		rs[RS_REMOTE] = REMOTE_MODE;
		rs[RS_MANUAL] = !AUTO_MODE;
		rs[RS_AUTO] = AUTO_MODE;
		rs[RS_STOPPED] = !running && !STOPPING;
		rs[RS_STOPPING] = STOPPING;
		rs[RS_ESTOP] = ESTOP_OPEN;
		rs[RS_RUN] = running;
		rs[RS_RUNNING_WITHOUT_REFERENCE] = running && ACTIVE_SETPOINT == 16'h0000;
		rs[RS_COAST] = COASTING;
		rs[RS_JOG] = JOGGING;
		rs[RS_FAULT] = fault_latched_reg;
	end

	assign dev_up = SPEED > ACTIVE_SETPOINT ? SPEED - ACTIVE_SETPOINT : '0;
	assign dev_dn = ACTIVE_SETPOINT > SPEED ? ACTIVE_SETPOINT - SPEED : '0;

	always_comb
	begin
		case (dfrs_qty_t'(relay_reg[R_QTY_LSB +: 3]))
			Q_MOTOR: qty = MOTOR_AMPS;
			Q_CLUTCH: qty = CLUTCH_AMPS;
			Q_BRAKE: qty = BRAKE_AMPS;
			Q_SETPT: qty = ACTIVE_SETPOINT;
			Q_SPEED: qty = SPEED;
			Q_DEV_UP: qty = dev_up;
			Q_DEV_DN: qty = dev_dn;
			default: qty = 16'h0000;
		endcase
	end

	assign cmp_hit = qty > relay_reg[31:16]; // RULE5
	assign relay_cond = relay_reg[R_CMP] ? cmp_hit
		: (relay_reg[4:0] <= RS_FAULT && rs[relay_reg[4:0]]); // RULE4

	always_ff @(posedge CORE_CLK or negedge RST_N)
	begin
		if (!RST_N)
			RELAY_OUT <= 1'b0;
		else
			RELAY_OUT <= relay_cond ^ relay_reg[R_INV]; // RULE3
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);

	chk_lost_programmed: assert property ( // RULE1
		follower_lost && follower_loss_choice
		|=> ACTIVE_SETPOINT == $past(flost_reg[31:16]))
		else $error("lost follower did not apply programmed setpoint");
	chk_lost_hold: assert property ( // RULE2
		AUTO_MODE && FOLLOWER <= flost_reg[15:0] && !follower_loss_choice
		|=> ACTIVE_SETPOINT == $past(hold_sp_reg))
		else $error("lost follower did not hold last setpoint");
	chk_relay_fault: assert property ( // RULE3
		!relay_reg[R_CMP] && relay_reg[4:0] == RS_FAULT
		&& fault_latched_reg |=> RELAY_OUT != $past(relay_reg[R_INV]))
		else $error("relay did not show latched fault");
	chk_local_gate: assert property ( // RULE6
		state_reg == ST_IDLE && !REMOTE_MODE && !KEY_START
		|=> state_reg == ST_IDLE)
		else $error("drive started without a local start");
	chk_stop_term: assert property ( // RULE9
		running && REMOTE_MODE && TERM_STOP |=> !running)
		else $error("terminal stop ignored");
	chk_hist_shift: assert property ( // RULE10
		ind_rise |=> hist_reg[1] == $past(hist_reg[0])
		&& hist_reg[4] == $past(hist_reg[3]))
		else $error("fault history did not shift");
	chk_hist_clear: assert property ( // RULE11
		clear_history && !ind_rise |=> hist_reg[0] == FC_NONE
		&& hist_reg[4] == FC_NONE)
		else $error("fault history not cleared");
	chk_fault_delay: assert property ( // RULE14
		time1_reg[15:0] != 16'h0000 && !fault_sensed ##1 fault_sensed
		|-> !ind_hit)
		else $error("fault indicated without delay");
	chk_retry_bound: assert property ( // RULE21
		ctrl_reg[C_FLT_RST] && $stable(retry_limit)
		&& retry_cnt_reg <= retry_limit |=> retry_cnt_reg <= retry_limit)
		else $error("retry count passed its limit");
	chk_retry_clear: assert property ( // RULE22
		retry_cnt_reg != '0 ##1 retry_cnt_reg == '0
		|-> $past(op_reset_reg) || $past(run_time_reg >= retry_reg[31:16]))
		else $error("retry count cleared early");
	chk_locked_hold: assert property ( // RULE23
		state_reg == ST_LOCKED && !op_reset_reg |=> state_reg == ST_LOCKED)
		else $error("locked fault released without reset");

	cov_fault_restart: cover property (restart_go);
	cov_locked: cover property (state_reg == ST_LOCKED);
	cov_relay_cmp: cover property (relay_reg[R_CMP] && $rose(RELAY_OUT));
	cov_pwr_run: cover property (state_q_reg == ST_PWR_WAIT && running);
endmodule

// ---- shared/dfrs_pkg.sv ----
// Constants and types shared by the drive fault and restart supervisor
package dfrs_pkg;
	localparam int CORE_CLK_HZ = 40_000_000;
	localparam int TICK_MS = 100;
	localparam int TICK_CYCLES = CORE_CLK_HZ / 1000 * TICK_MS;
	localparam int TICKS_PER_S = 1000 / TICK_MS;
	localparam int DELAY_DEF_S = 10;
	localparam int SPD_TRIP_DEF_S = 5;
	localparam int CLR_TIME_DEF_S = 60;
	localparam logic [15:0] DELAY_DEF_T = 16'(DELAY_DEF_S * TICKS_PER_S);
	localparam logic [15:0] SPD_TRIP_DEF_T = 16'(SPD_TRIP_DEF_S * TICKS_PER_S);
	localparam logic [15:0] CLR_TIME_DEF_T = 16'(CLR_TIME_DEF_S * TICKS_PER_S);
	localparam logic [3:0] RETRY_DEF = 4'h3;
	localparam int RETRY_W = 4;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_RELAY = 8'h04;
	localparam logic [7:0] A_FLOST = 8'h08;
	localparam logic [7:0] A_SPEED = 8'h0c;
	localparam logic [7:0] A_TIME1 = 8'h10;
	localparam logic [7:0] A_TIME2 = 8'h14;
	localparam logic [7:0] A_RETRY = 8'h18;
	localparam logic [7:0] A_CMD = 8'h1c;
	localparam logic [7:0] A_STATUS = 8'h20;
	localparam logic [7:0] A_HIST = 8'h24;

	localparam int C_LOSS_CHOICE = 0;
	localparam int C_STOP_PANEL = 1;
	localparam int C_OPEN_CHK = 2;
	localparam int C_FB_CHK = 3;
	localparam int C_PANEL_CHK = 4;
	localparam int C_HI_CHK = 5;
	localparam int C_HI_STOP = 6;
	localparam int C_LO_CHK = 7;
	localparam int C_LO_STOP = 8;
	localparam int C_PLC_AUTO = 9;
	localparam int C_PLC_RUN = 10;
	localparam int C_PWR_RST = 11;
	localparam int C_FLT_RST = 12;
	localparam int C_CLR_HIST = 13;
	localparam int R_CMP = 5;
	localparam int R_INV = 6;
	localparam int R_QTY_LSB = 8;
	localparam int CMD_RESET = 0;
	localparam int HIST_N = 5;

	typedef enum logic [4:0] {
		RS_RESTART, RS_TRQ_LIM, RS_AT_SP, RS_FOL_LOST, RS_FB_LOST,
		RS_SPD_MODE, RS_TRQ_MODE, RS_LOCAL, RS_REMOTE, RS_MANUAL, RS_AUTO,
		RS_STOPPED, RS_STOPPING, RS_ESTOP, RS_RUN, RS_RUNNING_WITHOUT_REFERENCE, RS_COAST,
		RS_JOG, RS_FAULT
	} dfrs_rstat_t;
	typedef enum logic [2:0] {
		Q_MOTOR, Q_CLUTCH, Q_BRAKE, Q_SETPT, Q_SPEED, Q_DEV_UP, Q_DEV_DN
	} dfrs_qty_t;
	typedef enum logic [2:0] {
		ST_PWR_WAIT, ST_IDLE, ST_RUN, ST_FLT_WAIT, ST_LOCKED
	} dfrs_state_t;
	typedef enum logic [3:0] {
		FC_NONE, FC_OPEN_COIL, FC_FB_LOSS, FC_PANEL, FC_OVERSPEED,
		FC_UNDERSPEED
	} dfrs_fault_t;

	localparam logic [31:0] CTRL_RST = 32'h0000_000d;
	localparam logic [31:0] RELAY_RST = {27'h0000000, RS_FAULT};
	localparam logic [31:0] FLOST_RST = 32'h0000_0000;
	localparam logic [31:0] SPEED_RST = 32'h0000_ffff;
	localparam logic [31:0] TIME1_RST = {SPD_TRIP_DEF_T, DELAY_DEF_T};
	localparam logic [31:0] TIME2_RST = {DELAY_DEF_T, DELAY_DEF_T};
	localparam logic [31:0] RETRY_RST = {CLR_TIME_DEF_T, 12'h000, RETRY_DEF};
endpackage

// ---- test/dfrs_panel_model.sv ----
// Model of the operator terminal strip and keypad
`timescale 1ns/1ps
module dfrs_panel_model (
	input  wire logic [1:0] press,
	output logic            term_start,
	output logic            key_start,
	output logic            key_stop,
	output logic            pad_on
);
	// Code 1 terminal start, 2 keypad start, 3 keypad stop
	assign term_start = press == 2'h1;
	assign key_start = press == 2'h2;
	assign key_stop = press == 2'h3;
	// Keypad stays plugged in; a missing panel is not modelled
	assign pad_on = 1'b1;
endmodule

// ---- test/drive_fault_restart_supervisor_tb.sv ----
// Self-checking bench for the drive fault and restart supervisor
`timescale 1ns/1ps
module drive_fault_restart_supervisor_tb;
	import dfrs_pkg::*;
	localparam int TK = 4;
	logic        clk, rst_n, psel, pen, pwr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        rdy, slverr, remote, auto_m, run, relay, flt;
	logic        ts, ks, kp, pad, tstop;
	logic [1:0]  press;
	logic [5:0]  stat;
	logic [15:0] spd, spt, fol, mamp, camp, bamp, act;
	int          n_fail, compares, seed, i, k;
	logic [31:0] tab [7];

	dfrs_top #(.TICK_CYCLES_P(TK)) u_dfrs_top (
		.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(rdy), .PSLVERR(slverr), .REMOTE_MODE(remote),
		.AUTO_MODE(auto_m), .TERM_START(ts), .TERM_STOP(tstop),
		.KEY_START(ks), .KEY_STOP(kp), .PLC_START(1'b0),
		.KEYPAD_PRESENT(pad), .SPEED_FB_OK(1'b1), .SPEED(spd),
		.SETPOINT_IN(spt), .FOLLOWER(fol), .MOTOR_AMPS(mamp),
		.CLUTCH_AMPS(camp), .BRAKE_AMPS(bamp), .TORQUE_LIMIT(stat[0]),
		.AT_SETPOINT(stat[1]), .TORQUE_MODE(stat[2]), .ESTOP_OPEN(1'b0),
		.STOPPING(stat[3]), .COASTING(stat[4]), .JOGGING(stat[5]),
		.RUN_CMD(run), .RELAY_OUT(relay), .FAULT_IND(flt),
		.ACTIVE_SETPOINT(act)
	);

	dfrs_panel_model u_dfrs_panel_model (
		.press(press), .term_start(ts), .key_start(ks), .key_stop(kp),
		.pad_on(pad)
	);

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, g);
		compares++;
		if (g !== e)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Request is held until pready is seen, then released
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk);
			if (rdy === 1'b1)
				break;
		end
		rd = prdata;
		err = slverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (n == 20)
		begin
			chk("pready", 32'h1, 32'h0);
			final_report();
		end
	endtask

	task automatic final_report;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial
	begin
		{rst_n, psel, pen, pwr, paddr, pwdata} = '0;
		{auto_m, tstop, press, stat, spd, spt, mamp, bamp} = '0;
		remote = 1'b1;
		fol = 16'h0800;
		camp = 16'h0040;
		n_fail = 0;
		compares = 0;
		seed = 33425;
		tab = '{CTRL_RST, RELAY_RST, FLOST_RST, SPEED_RST, TIME1_RST,
			TIME2_RST, RETRY_RST};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (k = 0; k < 7; k++)
		begin
			apb(1'b0, 8'(k * 4), 32'h0);
			chk("reg", tab[k], rd);
		end
		apb(1'b0, 8'h28, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		$display("test done: register defaults");
		// Short delays keep the run brief
		apb(1'b1, A_TIME2, 32'h0002_0002);
		apb(1'b1, A_TIME1, {SPD_TRIP_DEF_T, 16'h0003});
		repeat (40) @(posedge clk);
		press <= 2'h2;
		repeat (8) @(posedge clk);
		apb(1'b0, A_STATUS, 32'h0);
		chk("keystart", 32'h1, {29'h0, rd[2:0]});
		press <= 2'h1;
		for (i = 0; i < 50 && run !== 1'b1; i++)
			@(posedge clk);
		chk("run", 32'h1, {31'h0, run});
		press <= 2'h0;
		$display("test done: start sources");
		for (k = 0; k < 2; k++)
		begin
			apb(1'b1, A_RELAY,
				{16'h8000, 5'h0, Q_SPEED, 1'b0, k[0], 1'b1, 5'h0});
			for (i = 0; i < 8; i++)
			begin
				spd <= (i < 2) ? 16'h8000 + 16'(i) : 16'($random(seed));
				stat <= 6'($random(seed));
				mamp <= 16'($random(seed));
				bamp <= 16'($random(seed));
				spt <= 16'($random(seed));
				camp <= 16'($random(seed)) | 16'h1;
				repeat (3) @(posedge clk);
				chk("cmp", {31'h0, k[0] ^ (spd > 16'h8000)},
					{31'h0, relay});
			end
		end
		$display("test done: relay compare");
		stat <= 6'h0;
		apb(1'b1, A_RELAY, RELAY_RST);
		repeat (3) @(posedge clk);
		chk("relay", 32'h0, {31'h0, relay});
		camp <= 16'h0;
		for (i = 0; i < 200 && flt !== 1'b1; i++)
			@(posedge clk);
		chk("fault", 32'h1, {31'h0, flt});
		chk("delay", 32'h1, {31'h0, i >= 3 * TK});
		repeat (4) @(posedge clk);
		chk("relay", 32'h1, {31'h0, relay});
		chk("runcmd", 32'h0, {31'h0, run});
		apb(1'b0, A_HIST, 32'h0);
		chk("hist", {28'h0, FC_OPEN_COIL}, {28'h0, rd[3:0]});
		apb(1'b0, A_STATUS, 32'h0);
		chk("locked", 32'h4, {29'h0, rd[2:0]});
		// Follower dropping exactly onto the lost level
		apb(1'b1, A_FLOST, 32'h1234_0100);
		auto_m <= 1'b1;
		fol <= 16'h0100;
		repeat (4) @(posedge clk);
		chk("setpoint", 32'h1234, {16'h0, act});
		apb(1'b0, A_STATUS, 32'h0);
		chk("lost", 32'h1, {31'h0, rd[4]});
		apb(1'b1, A_CTRL, CTRL_RST | 32'h2000);
		apb(1'b0, A_HIST, 32'h0);
		chk("clear", 32'h0, rd);
		$display("test done: fault and history");
		// Hold-last choice, then restarts until the retry limit locks
		apb(1'b1, A_CTRL, 32'h0000_100c);
		repeat (2) @(posedge clk);
		chk("hold", {16'h0, spt}, {16'h0, act});
		apb(1'b1, A_RETRY, {CLR_TIME_DEF_T, 16'h0001});
		press <= 2'h1;
		apb(1'b1, A_CMD, 32'h1);
		repeat (150) @(posedge clk);
		apb(1'b0, A_STATUS, 32'h0);
		chk("retries", 32'h1, {28'h0, rd[11:8]});
		chk("relock", 32'h4, {29'h0, rd[2:0]});
		apb(1'b0, A_HIST, 32'h0);
		chk("hist2", 32'h11, rd);
		$display("test done: fault restart");
		// Local mode: terminal start ignored, keypad starts the drive
		camp <= 16'h0040;
		remote <= 1'b0;
		apb(1'b1, A_CMD, 32'h1);
		repeat (4) @(posedge clk);
		chk("local", 32'h0, {31'h0, run});
		press <= 2'h2;
		for (i = 0; i < 20 && run !== 1'b1; i++)
			@(posedge clk);
		chk("keyrun", 32'h1, {31'h0, run});
		// Stop source is terminal only, so the keypad stop is ignored
		press <= 2'h3;
		repeat (4) @(posedge clk);
		chk("keystop", 32'h1, {31'h0, run});
		remote <= 1'b1;
		tstop <= 1'b1;
		repeat (4) @(posedge clk);
		chk("termstop", 32'h0, {31'h0, run});
		$display("test done: local and stop");
		final_report();
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule
